//--- logic/mcr_pkg.sv
/*
 * constants, register map and carrier types for the meter configuration slice.
 * assumes an APB master with 32-bit data, one aligned word per register.
 */
package mcr_pkg;
    // printed offsets are not all multiples of four: they are indices, byte address = 4*index
    localparam logic [15:0] IDX_FLASH_PROTECT = 16'h00B2;
    localparam logic [15:0] IDX_SERIAL_CMD = 16'h00FD;
    localparam logic [15:0] IDX_SLOT_STRETCH = 16'h2112;
    localparam logic [15:0] IDX_TEMP_UPPER = 16'h251B;
    localparam logic [15:0] IDX_TEMP_LOWER = 16'h251C;
    localparam logic [15:0] IDX_TEMP_FILTER = 16'h251D;
    localparam logic [15:0] IDX_SERIAL_EN = 16'h270C;
    localparam logic [15:0] IDX_SLEEP_REQ = 16'h28B2;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'h3000;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h3001;
    localparam logic [15:0] IDX_POWER_STATUS = 16'h3002;
    localparam logic [15:0] IDX_DISPLAY_MAP = 16'h3003;
    localparam logic [15:0] IDX_COMPUTE_LOC = 16'h3004;

    // bit positions
    localparam int FLASH_PROTECT_CTL_BIT = 6;
    localparam int SLEEP_BIT = 7;
    localparam int SERIAL_EN_BIT = 4;

    // reset values
    localparam logic RST_FLASH_PROTECT_CTL = 1'h0;
    localparam logic RST_SERIAL_EN = 1'h1;
    localparam logic [3:0] RST_STRETCH = 4'h0;
    localparam logic [6:0] RST_TEMP_LIMIT = 7'h00;
    localparam logic [3:0] RST_FILTER = 4'h0;
    localparam logic [7:0] RST_CMD = 8'h00;
    localparam logic [3:0] RST_DISPLAY_MAP = 4'h0;
    localparam logic [6:0] RST_COMPUTE_LOC = 7'h00;
    localparam logic [3:0] RST_IRQ = 4'h0;

    // result scaling
    localparam int SHIFT_NO_STRETCH = 9;
    localparam int SHIFT_STRETCH = 4;
    localparam int ADC_W = 22;
    localparam int RES_W = 32;

    // flash geometry: page size as address bits, code location in pages
    localparam int FLASH_AW = 17;
    localparam int PAGE_BITS = 10;

    // irq status bits
    localparam int IRQ_CMD = 0;
    localparam int IRQ_SLEEP = 1;
    localparam int IRQ_WAKE = 2;
    localparam int IRQ_ERASE_DENY = 3;

    typedef enum logic [2:0] {
        PWR_ACTIVE = 3'b001,
        PWR_ENTER = 3'b010,
        PWR_SLEEP = 3'b100
    } mcr_pwr_t;

    typedef struct packed {
        logic req;
        logic [FLASH_AW-1:0] addr;
    } mcr_erase_t;

    typedef struct packed {
        logic timer;
        logic button;
        logic sysPower;
    } mcr_wake_t;
endpackage : mcr_pkg

//--- logic/mcr_slot_stretch.sv
/*
 * slot-zero stretch counter and result scaler.
 * assumes xtalTick is a one-cycle pulse already in the clock domain.
 */
`timescale 1ns/1ns
module mcr_slot_stretch (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control
    input wire logic [3:0] stretch,
    input wire logic slotEnd,
    input wire logic xtalTick,
    input wire logic [mcr_pkg::ADC_W-1:0] adcRaw,
    input wire logic adcValid,
    // results
    output logic slotHold,
    output logic [mcr_pkg::RES_W-1:0] result
);
    import mcr_pkg::*;
    logic [3:0] extra;
    logic busy;
    wire logic startExt = slotEnd && !busy && (stretch != 4'h0);
    wire logic [RES_W-1:0] wide = {{(RES_W-ADC_W){1'b0}}, adcRaw};
    wire logic [RES_W-1:0] scaled = (stretch == 4'h0) ? (wide << SHIFT_NO_STRETCH)
                                                       : (wide << SHIFT_STRETCH);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            extra <= 4'h0;
            busy <= 1'b0;
        end else if (startExt) begin
            extra <= stretch;
            busy <= 1'b1;
        end else if (busy && xtalTick) begin
            extra <= extra - 4'h1;
            busy <= (extra != 4'h1);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            slotHold <= 1'b0;
            result <= '0;
        end else begin
            slotHold <= startExt || (busy && !(xtalTick && extra == 4'h1));
            if (adcValid)
                result <= scaled;
        end
    end
endmodule : mcr_slot_stretch

//--- logic/mcr_config_slice.sv
/*
 * meter configuration register slice: flash security gate, temperature limits,
 * sleep request with wake, slot-zero stretch, serial command capture, port enable.
 * assumes an APB master on clock, and wake and serial command pins that may be asynchronous.
 */
`timescale 1ns/1ns
module mcr_config_slice (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial slave command capture
    input wire logic [7:0] serialCmd,
    input wire logic serialCmdValid,
    // flash access requests
    input wire mcr_pkg::mcr_erase_t eraseReq,
    input wire logic serialFlashRead,
    input wire logic emulatorFlashRead,
    output logic eraseGrant,
    output logic eraseDeny,
    output logic serialReadGrant,
    output logic emulatorReadGrant,
    // power
    input wire mcr_pkg::mcr_wake_t wakePins,
    output logic sleepState,
    // adc slot zero
    input wire logic slotEnd,
    input wire logic xtalTick,
    input wire logic [mcr_pkg::ADC_W-1:0] adcRaw,
    input wire logic adcValid,
    output logic slotHold,
    output logic [mcr_pkg::RES_W-1:0] slotResult,
    // temperature settings
    output logic [6:0] tempUpperLimit,
    output logic [6:0] tempLowerLimit,
    output logic [3:0] tempWakeFilter,
    // pin routing
    output logic serialOnSharedIo,
    // interrupt
    output logic irq
);
    import mcr_pkg::*;

    function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
        hit = (a[17:2] == idx) && (a[1:0] == 2'b00);
    endfunction : hit

    logic flash_protect_ctl;
    logic [7:0] cmdCapture;
    logic [3:0] stretch;
    logic serialEn;
    logic [3:0] displayPinMap;
    logic [6:0] computeCodeLocation;
    logic [3:0] irqStatus;
    logic [3:0] irqMask;
    mcr_pwr_t pwr;
    mcr_pwr_t next_pwr;
    mcr_wake_t wakeMeta;
    mcr_wake_t wakeSync;
    logic [2:0] cmdMeta;
    logic [2:0] cmdSync;
    logic [7:0] cmdData;

    // one-cycle apb: answer on the first access cycle
    wire logic access = psel && penable;
    wire logic wrEn = access && pwrite && pstrb[0];
    wire logic selSecure = hit(paddr, IDX_FLASH_PROTECT);
    wire logic selCmd = hit(paddr, IDX_SERIAL_CMD);
    wire logic selStretch = hit(paddr, IDX_SLOT_STRETCH);
    wire logic selUpper = hit(paddr, IDX_TEMP_UPPER);
    wire logic selLower = hit(paddr, IDX_TEMP_LOWER);
    wire logic selFilter = hit(paddr, IDX_TEMP_FILTER);
    wire logic selSerEn = hit(paddr, IDX_SERIAL_EN);
    wire logic selSleep = hit(paddr, IDX_SLEEP_REQ);
    wire logic selIrqSt = hit(paddr, IDX_IRQ_STATUS);
    wire logic selIrqMask = hit(paddr, IDX_IRQ_MASK);
    wire logic selPwr = hit(paddr, IDX_POWER_STATUS);
    wire logic selMap = hit(paddr, IDX_DISPLAY_MAP);
    wire logic selLoc = hit(paddr, IDX_COMPUTE_LOC);
    wire logic mapped = selSecure | selCmd | selStretch | selUpper | selLower | selFilter
                      | selSerEn | selSleep | selIrqSt | selIrqMask | selPwr | selMap | selLoc;
    // the command byte is fixed by the serial side, so writes to it are errors
    wire logic badWrite = pwrite && (selCmd || selPwr);
    wire logic busErr = !mapped || badWrite;

    wire logic [31:0] rdMux =
        selSecure ? {25'h0, flash_protect_ctl, 6'h0} :
        selCmd ? {24'h0, cmdCapture} :
        selStretch ? {28'h0, stretch} :
        selUpper ? {25'h0, tempUpperLimit} :
        selLower ? {25'h0, tempLowerLimit} :
        selFilter ? {28'h0, tempWakeFilter} :
        selSerEn ? {27'h0, serialEn, 4'h0} :
        selIrqSt ? {28'h0, irqStatus} :
        selIrqMask ? {28'h0, irqMask} :
        selPwr ? {29'h0, pwr} :
        selMap ? {28'h0, displayPinMap} :
        selLoc ? {25'h0, computeCodeLocation} :
        32'h0;

    // flash gate: page index against compute-code start
    wire logic [FLASH_AW-PAGE_BITS-1:0] erasePage = eraseReq.addr[FLASH_AW-1:PAGE_BITS];
    wire logic protectedPage = (erasePage == '0) || (erasePage >= computeCodeLocation);
    wire logic denyErase = eraseReq.req && flash_protect_ctl && protectedPage;
    wire logic allowErase = eraseReq.req && !denyErase;

    // sleep request and wake
    wire logic sleepWrite = wrEn && selSleep && pwdata[SLEEP_BIT];
    wire logic wakeEvent = wakeSync.timer || wakeSync.button || wakeSync.sysPower;
    wire logic cmdStrobe = cmdSync[2] ^ cmdSync[1];

    always_comb begin
        next_pwr = pwr;
        unique case (pwr)
            PWR_ACTIVE: begin
                if (sleepWrite && !wakeSync.sysPower)
                    next_pwr = PWR_ENTER;
            end
            PWR_ENTER: begin
                next_pwr = wakeSync.sysPower ? PWR_ACTIVE : PWR_SLEEP;
            end
            PWR_SLEEP: begin
                if (wakeEvent)
                    next_pwr = PWR_ACTIVE;
            end
            default: next_pwr = PWR_ACTIVE;
        endcase
    end

    // wake pins are asynchronous levels: two flops before any decode
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wakeMeta <= '0;
            wakeSync <= '0;
        end else begin
            wakeMeta <= wakePins;
            wakeSync <= wakeMeta;
        end
    end

    // the byte is taken only after the toggle settles, so one flop suffices
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cmdMeta <= 3'h0;
            cmdSync <= 3'h0;
            cmdData <= RST_CMD;
        end else begin
            cmdMeta <= {cmdMeta[1:0], serialCmdValid};
            cmdSync <= {cmdSync[1:0], cmdMeta[2]};
            cmdData <= serialCmd;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            pwr <= PWR_ACTIVE;
        else
            pwr <= next_pwr;
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            flash_protect_ctl <= RST_FLASH_PROTECT_CTL;
        else if (wrEn && selSecure)
            flash_protect_ctl <= pwdata[FLASH_PROTECT_CTL_BIT];
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            stretch <= RST_STRETCH;
        else if (wrEn && selStretch)
            stretch <= pwdata[3:0];
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            tempUpperLimit <= RST_TEMP_LIMIT;
        else if (wrEn && selUpper)
            tempUpperLimit <= pwdata[6:0];
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            tempLowerLimit <= RST_TEMP_LIMIT;
        else if (wrEn && selLower)
            tempLowerLimit <= pwdata[6:0];
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            tempWakeFilter <= RST_FILTER;
        else if (wrEn && selFilter)
            tempWakeFilter <= pwdata[3:0];
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            serialEn <= RST_SERIAL_EN;
        else if (wrEn && selSerEn)
            serialEn <= pwdata[SERIAL_EN_BIT];
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            displayPinMap <= RST_DISPLAY_MAP;
        else if (wrEn && selMap)
            displayPinMap <= pwdata[3:0];
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            computeCodeLocation <= RST_COMPUTE_LOC;
        else if (wrEn && selLoc)
            computeCodeLocation <= pwdata[6:0];
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            irqMask <= RST_IRQ;
        else if (wrEn && selIrqMask)
            irqMask <= pwdata[3:0];
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            cmdCapture <= RST_CMD;
        else if (cmdStrobe)
            cmdCapture <= cmdData;
    end

    // sticky status: a new event wins over a write-one clear in the same cycle
    wire logic [3:0] irqEvents = {denyErase, (pwr == PWR_SLEEP) && wakeEvent,
                                  next_pwr == PWR_SLEEP && pwr != PWR_SLEEP, cmdStrobe};
    wire logic [3:0] irqClear = (wrEn && selIrqSt) ? pwdata[3:0] : 4'h0;
    wire logic [3:0] next_irqStatus = (irqStatus & ~irqClear) | irqEvents;

    always_ff @(posedge clock) begin
        if (!rst_n)
            irqStatus <= RST_IRQ;
        else
            irqStatus <= next_irqStatus;
    end

    // answer is launched from the setup cycle, so it stands in the first access cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && busErr;
            prdata <= (psel && !penable && !pwrite) ? rdMux : 32'h0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            eraseGrant <= 1'b0;
            eraseDeny <= 1'b0;
        end else begin
            eraseGrant <= allowErase;
            eraseDeny <= denyErase;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            serialReadGrant <= 1'b0;
            emulatorReadGrant <= 1'b0;
        end else begin
            serialReadGrant <= serialFlashRead && !flash_protect_ctl;
            emulatorReadGrant <= emulatorFlashRead && !flash_protect_ctl;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            sleepState <= 1'b0;
        else
            sleepState <= (next_pwr == PWR_SLEEP);
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            serialOnSharedIo <= 1'b0;
        else
            serialOnSharedIo <= serialEn && (displayPinMap == 4'h0);
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(next_irqStatus & irqMask);
    end

    mcr_slot_stretch i_mcr_slot_stretch (
        .clock(clock),
        .rst_n(rst_n),
        .stretch(stretch),
        .slotEnd(slotEnd),
        .xtalTick(xtalTick),
        .adcRaw(adcRaw),
        .adcValid(adcValid),
        .slotHold(slotHold),
        .result(slotResult)
    );
endmodule : mcr_config_slice

//--- dv/mcr_config_slice_sva.sv
/*
 * port checker for the configuration slice.
 * assumes zero-wait apb and the register indices of mcr_pkg.
 */
`timescale 1ns/1ns
module mcr_config_slice_sva
    import mcr_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // flash
    input wire mcr_pkg::mcr_erase_t eraseReq,
    input wire logic serialFlashRead,
    input wire logic emulatorFlashRead,
    input wire logic eraseGrant,
    input wire logic eraseDeny,
    input wire logic serialReadGrant,
    input wire logic emulatorReadGrant,
    // power
    input wire mcr_pkg::mcr_wake_t wakePins,
    input wire logic sleepState,
    // slot zero
    input wire logic slotEnd,
    input wire logic xtalTick,
    input wire logic [mcr_pkg::ADC_W-1:0] adcRaw,
    input wire logic adcValid,
    input wire logic slotHold,
    input wire logic [mcr_pkg::RES_W-1:0] slotResult
);
    logic wrDone;
    logic flash_protect_ctl;
    logic [3:0] stretch;
    logic [3:0] tickCnt;
    // strobes are ignored: the bench writes whole words to the registers tracked here
    assign wrDone = psel && penable && pready && pwrite && !pslverr;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flash_protect_ctl <= RST_FLASH_PROTECT_CTL;
            stretch <= RST_STRETCH;
        end else if (wrDone && paddr == {IDX_FLASH_PROTECT, 2'b00}) begin
            flash_protect_ctl <= pwdata[FLASH_PROTECT_CTL_BIT];
        end else if (wrDone && paddr == {IDX_SLOT_STRETCH, 2'b00}) begin
            stretch <= pwdata[3:0];
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n || !slotHold) begin
            tickCnt <= 4'h0;
        end else if (xtalTick) begin
            tickCnt <= tickCnt + 4'h1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence quietPins;
        (wakePins == 3'h0) [*3];
    endsequence
    sequence sleepWrite;
        wrDone && paddr == {IDX_SLEEP_REQ, 2'b00} && pwdata[SLEEP_BIT];
    endsequence
    chk_erase_page0: assert property (
        eraseReq.req && flash_protect_ctl && eraseReq.addr[16:10] == 7'h00 |=> eraseDeny && !eraseGrant)
        else $error("page zero erase not refused");
    chk_read_block: assert property (
        (serialFlashRead || emulatorFlashRead) && flash_protect_ctl
        |=> !serialReadGrant && !emulatorReadGrant) else $error("flash_protect_ctl read granted");
    chk_sleep_enter: assert property (
        quietPins ##0 sleepWrite |-> ##2 sleepState) else $error("sleep not entered");
    chk_wake_any: assert property (
        sleepState && wakePins != 3'h0 |-> ##[1:4] !sleepState) else $error("no wake");
    chk_hold_start: assert property (
        slotEnd && stretch != 4'h0 |=> slotHold) else $error("slot not stretched");
    chk_hold_len: assert property (
        slotHold |-> tickCnt < stretch) else $error("slot stretched too long");
    chk_shift_plain: assert property (
        adcValid && stretch == 4'h0 |=> slotResult == {1'b0, $past(adcRaw), 9'h000})
        else $error("plain shift wrong");
    chk_shift_long: assert property (
        adcValid && stretch != 4'h0 |=> slotResult == {6'h00, $past(adcRaw), 4'h0})
        else $error("stretched shift wrong");
endmodule : mcr_config_slice_sva
bind mcr_config_slice mcr_config_slice_sva i_chk (.*);

//--- dv/mcr_serial_host.sv
/*
 * serial bus master model: command bytes and flash read requests.
 * assumes the caller starts tasks from procedural bench code.
 */
`timescale 1ns/1ns
module mcr_serial_host (
    // clock
    input wire logic clock,
    // serial side
    output logic [7:0] serialCmd,
    output logic serialCmdValid,
    output logic serialFlashRead
);
    initial begin
        serialCmd = 8'h00;
        serialCmdValid = 1'b0;
        serialFlashRead = 1'b0;
    end
    task automatic send(input logic [7:0] b);
        @(posedge clock);
        serialCmd <= b;
        serialCmdValid <= ~serialCmdValid;
        repeat (6) @(posedge clock);
        // hold time over: a stale byte must not pass by luck
        serialCmd <= ~b;
    endtask : send
    task automatic flashRead(input logic v);
        @(posedge clock);
        serialFlashRead <= v;
    endtask : flashRead
endmodule : mcr_serial_host

//--- dv/test_mcr_config_slice.sv
/*
 * self-checking bench for the configuration slice over apb.
 * assumes the host model and checker are compiled before it.
 */
`timescale 1ns/1ns
module test_mcr_config_slice;
    import mcr_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready, pslverr, serialCmdValid, serialFlashRead, emulatorFlashRead = 1'b0;
    logic [7:0] serialCmd;
    mcr_erase_t eraseReq = '0;
    logic eraseGrant, eraseDeny, serialReadGrant, emulatorReadGrant, sleepState;
    mcr_wake_t wakePins = '0;
    logic slotEnd = 1'b0;
    logic xtalTick = 1'b0;
    logic adcValid = 1'b0;
    logic [ADC_W-1:0] adcRaw = 22'h3FFFFF;
    logic slotHold, serialOnSharedIo, irq;
    logic [RES_W-1:0] slotResult;
    logic [6:0] tempUpperLimit, tempLowerLimit;
    logic [3:0] tempWakeFilter;
    logic [31:0] q;
    logic e;
    logic dn;
    int failures = 0;
    int checks = 0;
    int ticks = 0;
    int t0;
    logic [15:0] ri [3] = '{IDX_TEMP_UPPER, IDX_TEMP_LOWER, IDX_TEMP_FILTER};
    logic [31:0] rx [3] = '{32'h7F, 32'h7F, 32'hF};
    logic [6:0] pg [5] = '{7'h00, 7'h05, 7'h0F, 7'h10, 7'h7F};
    logic [3:0] sv [3] = '{4'h0, 4'h1, 4'hF};
    always #5 clock = ~clock;
    always @(posedge clock) if (slotHold === 1'b1 && xtalTick === 1'b1) ticks <= ticks + 1;
    mcr_config_slice i_mcr_config_slice (.*);
    mcr_serial_host i_mcr_serial_host (.clock(clock), .serialCmd(serialCmd),
        .serialCmdValid(serialCmdValid), .serialFlashRead(serialFlashRead));
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic apb(input logic [15:0] i, input logic w, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // the wait ends when pready is seen high, or by the watchdog if it never is
        do
            @(posedge clock);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input string n, input logic [15:0] i, input logic [31:0] x);
        apb(i, 1'b0, 32'h0);
        chk(n, x, q);
    endtask : rd
    task automatic nx;
        @(posedge clock);
        @(negedge clock);
    endtask : nx
    task automatic test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    initial begin
        #100000;
        failures++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rd("flash_protect_ctl", IDX_FLASH_PROTECT, 32'h0);
        rd("port enable", IDX_SERIAL_EN, 32'h10);
        chk("shared io", 32'h1, serialOnSharedIo);
        rd("sleep reads", IDX_SLEEP_REQ, 32'h0);
        rd("power state", IDX_POWER_STATUS, 32'h1);
        foreach (ri[k]) begin
            rd("reset field", ri[k], 32'h0);
            apb(ri[k], 1'b1, 32'hFFFFFFFF);
            rd("rw field", ri[k], rx[k]);
        end
        pstrb <= 4'h0;
        apb(IDX_TEMP_FILTER, 1'b1, 32'h0);
        pstrb <= 4'hF;
        rd("strobe ignored", IDX_TEMP_FILTER, 32'hF);
        apb(IDX_TEMP_LOWER, 1'b1, 32'h15);
        nx();
        chk("lower port", 32'h15, tempLowerLimit);
        chk("upper port", 32'h7F, tempUpperLimit);
        chk("filter port", 32'hF, tempWakeFilter);
        apb(16'h1000, 1'b0, 32'h0);
        chk("unmapped", 32'h1, e);
        $display("test registers done");
        i_mcr_serial_host.send(8'hA5);
        rd("command", IDX_SERIAL_CMD, 32'hA5);
        chk("irq masked", 32'h0, irq);
        apb(IDX_IRQ_MASK, 1'b1, 32'h1);
        nx();
        chk("irq raised", 32'h1, irq);
        apb(IDX_IRQ_STATUS, 1'b1, 32'h1);
        nx();
        chk("irq cleared", 32'h0, irq);
        apb(IDX_SERIAL_CMD, 1'b1, 32'h0);
        chk("command read only", 32'h1, e);
        $display("test command done");
        apb(IDX_COMPUTE_LOC, 1'b1, 32'h10);
        i_mcr_serial_host.flashRead(1'b1);
        for (int s = 0; s < 2; s++) begin
            apb(IDX_FLASH_PROTECT, 1'b1, 32'(s) << FLASH_PROTECT_CTL_BIT);
            foreach (pg[k]) begin
                @(posedge clock);
                eraseReq <= '{1'b1, {pg[k], 10'h000}};
                emulatorFlashRead <= 1'b1;
                nx();
                dn = s == 1 && (pg[k] == 7'h00 || pg[k] >= 7'h10);
                chk("erase deny", dn, eraseDeny);
                chk("erase grant", !dn, eraseGrant);
                chk("serial read", s == 0, serialReadGrant);
                chk("emulator read", s == 0, emulatorReadGrant);
            end
        end
        $display("test flash done");
        for (int k = 2; k >= 0; k--) begin
            apb(IDX_SLEEP_REQ, 1'b1, 32'h80);
            repeat (3) @(posedge clock);
            nx();
            chk("asleep", 32'h1, sleepState);
            @(posedge clock) wakePins <= 3'b001 << k;
            repeat (6) @(posedge clock);
            nx();
            chk("woken", 32'h0, sleepState);
            if (k > 0) @(posedge clock) wakePins <= '0;
        end
        apb(IDX_SLEEP_REQ, 1'b1, 32'h80);
        repeat (3) @(posedge clock);
        nx();
        chk("powered sleep", 32'h0, sleepState);
        @(posedge clock) wakePins <= '0;
        rd("irq status", IDX_IRQ_STATUS, 32'hE);
        $display("test sleep done");
        foreach (sv[k]) begin
            apb(IDX_SLOT_STRETCH, 1'b1, 32'(sv[k]));
            t0 = ticks;
            slotEnd <= 1'b1;
            adcValid <= 1'b1;
            @(posedge clock);
            slotEnd <= 1'b0;
            adcValid <= 1'b0;
            @(negedge clock);
            chk("result", sv[k] == 0 ? 32'h7FFFFE00 : 32'h03FFFFF0, slotResult);
            repeat (40) @(posedge clock) xtalTick <= ~xtalTick;
            chk("ticks", 32'(sv[k]), 32'(ticks - t0));
        end
        $display("test stretch done");
        apb(IDX_DISPLAY_MAP, 1'b1, 32'h1);
        nx();
        chk("io mapped", 32'h0, serialOnSharedIo);
        apb(IDX_DISPLAY_MAP, 1'b1, 32'h0);
        nx();
        chk("io restored", 32'h1, serialOnSharedIo);
        apb(IDX_SERIAL_EN, 1'b1, 32'h0);
        nx();
        chk("io disabled", 32'h0, serialOnSharedIo);
        $display("test routing done");
        test_done();
    end
endmodule : test_mcr_config_slice
